/* File: hdl/iba_addr_store.sv */
`timescale 1ns/10ps
`include "iba_consts.svh"
// Holds the primary address captured once after power-up
module iba_addr_store
	import iba_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input iba_pkg::iba_addr_t switches,
	output iba_pkg::iba_addr_t addr_q,
	output logic captured_q
);
	logic captured_reg;
	iba_addr_t addr_reg;
	wire logic take = !captured_reg;

	// Capture once after reset release, then hold
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			captured_reg <= 1'b0;
			addr_reg <= `IBA_PA_DEFAULT;
		end else if (take) begin
			captured_reg <= 1'b1;
			addr_reg <= switches;
		end
	end

	assign addr_q = addr_reg;
	assign captured_q = captured_reg;
endmodule

/* File: hdl/iba_consts.svh */
`ifndef IBA_CONSTS_SVH
`define IBA_CONSTS_SVH
// Primary address field and type field of an address byte
// Bus lines count from one, so field bits 5..1 sit at [4:0], type bits 7..6 at [6:5]
`define IBA_PA_LSB 0
`define IBA_PA_MSB 4
`define IBA_TYPE_LSB 5
`define IBA_TYPE_MSB 6
// Top and bottom bits of the stored address
`define IBA_ADDR_TOP 4
`define IBA_ADDR_BOTTOM 0
// Byte type codes: listen 32+addr, talk 64+addr, secondary both bits set
`define IBA_TYPE_LISTEN 2'h1
`define IBA_TYPE_TALK 2'h2
`define IBA_TYPE_SECONDARY 2'h3
`define IBA_TYPE_COMMAND 2'h0
// Address that takes the device off the bus
`define IBA_PA_OFFBUS 5'h1F
// Factory default address
`define IBA_PA_DEFAULT 5'h1C
// Characters
`define IBA_CHAR_LF 8'h0A
`define IBA_CHAR_CR 8'h0D
`endif

/* File: hdl/iba_match.sv */
`timescale 1ns/10ps
`include "iba_consts.svh"
module iba_match
	import iba_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic addr_switch_msb,
	input wire logic addr_switch_bit3,
	input wire logic addr_switch_bit2,
	input wire logic addr_switch_bit1,
	input wire logic addr_switch_lsb,
	input wire logic newline_or_end_termination,
	input wire logic rx_valid,
	input iba_pkg::iba_byte_t rx_data,
	input wire logic rx_atn,
	input wire logic rx_eoi,
	input wire logic tx_valid,
	input iba_pkg::iba_byte_t tx_data,
	input wire logic tx_last,
	input wire logic tx_accept,
	output logic listen_q,
	output logic talk_q,
	output logic msg_valid_q,
	output iba_pkg::iba_byte_t msg_data_q,
	output logic msg_end_q,
	output logic tx_ready_q,
	output logic out_valid_q,
	output iba_pkg::iba_byte_t out_data_q,
	output logic out_eoi_q,
	output iba_pkg::iba_addr_t primary_addr_q
);
	logic listen_reg, listen_next, talk_reg, talk_next;
	logic msg_valid_reg, msg_end_reg, out_valid_reg, out_eoi_reg, tx_ready_reg;
	iba_byte_t msg_data_reg, out_data_reg;
	iba_tx_state_t tx_reg, tx_next;
	iba_addr_t stored;
	logic captured;

	wire iba_addr_t switches = {addr_switch_msb, addr_switch_bit3, addr_switch_bit2, addr_switch_bit1, addr_switch_lsb};

	iba_addr_store u_store (
		.clk(clk),
		.nrst(nrst),
		.switches(switches),
		.addr_q(stored),
		.captured_q(captured)
	);

	// Address decode of a received byte
	wire logic [1:0] byte_type = rx_data[`IBA_TYPE_MSB:`IBA_TYPE_LSB];
	wire logic pa_hit = rx_data[`IBA_PA_MSB:`IBA_PA_LSB] == stored;
	wire logic on_bus = captured && (stored != `IBA_PA_OFFBUS);
	wire logic addr_cyc = rx_valid && rx_atn && on_bus;
	wire logic my_listen = addr_cyc && byte_type == `IBA_TYPE_LISTEN && pa_hit;
	wire logic my_talk = addr_cyc && byte_type == `IBA_TYPE_TALK && pa_hit;
	wire logic is_lf = rx_data == `IBA_CHAR_LF;
	wire logic data_cyc = rx_valid && !rx_atn && listen_reg;
	wire logic rx_end = rx_eoi || (newline_or_end_termination && is_lf);

	// addressed state; secondary and other bytes hold state
	always_comb begin
		listen_next = listen_reg;
		talk_next = talk_reg;
		if (!on_bus) begin
			listen_next = 1'b0;
			talk_next = 1'b0;
		end else if (my_listen) begin
			listen_next = 1'b1;
		end else if (my_talk) begin
			talk_next = 1'b1;
		end
	end

	wire logic tx_take = tx_reg == IBA_TX_IDLE && tx_valid && talk_reg && (!out_valid_reg || tx_accept);
	wire logic out_free = !out_valid_reg || tx_accept;
	always_comb begin
		case (tx_reg)
			IBA_TX_IDLE: tx_next = (tx_take && tx_last && newline_or_end_termination) ? IBA_TX_CR : IBA_TX_IDLE;
			IBA_TX_CR: tx_next = out_free ? IBA_TX_LF : IBA_TX_CR;
			IBA_TX_LF: tx_next = out_free ? IBA_TX_IDLE : IBA_TX_LF;
			default: tx_next = IBA_TX_IDLE;
		endcase
	end

	// Addressed state registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			listen_reg <= 1'b0;
			talk_reg <= 1'b0;
		end else begin
			listen_reg <= listen_next;
			talk_reg <= talk_next;
		end
	end

	// Received message data path
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msg_valid_reg <= 1'b0;
			msg_data_reg <= 8'h00;
			msg_end_reg <= 1'b0;
		end else begin
			msg_valid_reg <= data_cyc;
			msg_data_reg <= data_cyc ? rx_data : msg_data_reg;
			msg_end_reg <= data_cyc && rx_end;
		end
	end

	// Output byte register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_reg <= IBA_TX_IDLE;
			tx_ready_reg <= 1'b1;
			out_valid_reg <= 1'b0;
			out_data_reg <= 8'h00;
			out_eoi_reg <= 1'b0;
		end else begin
			tx_reg <= tx_next;
			tx_ready_reg <= tx_next == IBA_TX_IDLE;
			if (tx_take) begin
				out_valid_reg <= 1'b1;
				out_data_reg <= tx_data;
				out_eoi_reg <= tx_last && !newline_or_end_termination;
			end else if (tx_reg == IBA_TX_CR && out_free) begin
				out_valid_reg <= 1'b1;
				out_data_reg <= `IBA_CHAR_CR;
				out_eoi_reg <= 1'b0;
			end else if (tx_reg == IBA_TX_LF && out_free) begin
				out_valid_reg <= 1'b1;
				out_data_reg <= `IBA_CHAR_LF;
				out_eoi_reg <= 1'b1;
			end else if (tx_accept) begin
				out_valid_reg <= 1'b0;
				out_eoi_reg <= 1'b0;
			end
		end
	end

	assign listen_q = listen_reg;
	assign talk_q = talk_reg;
	assign msg_valid_q = msg_valid_reg;
	assign msg_data_q = msg_data_reg;
	assign msg_end_q = msg_end_reg;
	assign tx_ready_q = tx_ready_reg;
	assign out_valid_q = out_valid_reg;
	assign out_data_q = out_data_reg;
	assign out_eoi_q = out_eoi_reg;
	assign primary_addr_q = stored;

	// Assertions
	// listen on match
	property p_listen;
		@(posedge clk) disable iff (!nrst) my_listen |=> listen_reg;
	endproperty
	listen_on_match_a: assert property (p_listen) else $error("listen not set on own address");
	talk_on_match_a: assert property (@(posedge clk) disable iff (!nrst)
		my_talk && !my_listen |=> talk_reg)
		else $error("talk not set on own address");
	secondary_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
		rx_valid && byte_type == `IBA_TYPE_SECONDARY && on_bus |=> $stable(listen_reg) && $stable(talk_reg))
		else $error("secondary byte changed state");
	offbus_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		captured && stored == `IBA_PA_OFFBUS |=> !listen_reg && !talk_reg)
		else $error("address 31 device addressed");
	addr_held_a: assert property (@(posedge clk) disable iff (!nrst)
		captured |=> $stable(stored))
		else $error("primary address changed");
	default_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		!captured |-> stored == `IBA_PA_DEFAULT)
		else $error("default address not shown before capture");
	no_atn_no_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		rx_valid && !rx_atn && on_bus |=> listen_reg == $past(listen_reg))
		else $error("data byte changed listen");
	end_on_eoi_a: assert property (@(posedge clk) disable iff (!nrst)
		data_cyc && rx_eoi |=> msg_end_reg)
		else $error("EOI did not end message");
	lf_end_a: assert property (@(posedge clk) disable iff (!nrst)
		data_cyc && newline_or_end_termination && is_lf |=> msg_end_reg)
		else $error("LF did not end message");
	last_eoi_a: assert property (@(posedge clk) disable iff (!nrst)
		tx_take && tx_last && !newline_or_end_termination |=> out_valid_reg && out_eoi_reg)
		else $error("final byte sent without EOI");
	nl_last_plain_a: assert property (@(posedge clk) disable iff (!nrst)
		tx_take && tx_last && newline_or_end_termination |=> out_valid_reg && !out_eoi_reg)
		else $error("final byte carried EOI before CR LF");
	sequence s_cr_sent;
		out_valid_reg && out_data_reg == `IBA_CHAR_CR && tx_accept && tx_reg == IBA_TX_LF;
	endsequence
	cr_then_lf_a: assert property (@(posedge clk) disable iff (!nrst)
		s_cr_sent |=> out_valid_reg && out_data_reg == `IBA_CHAR_LF && out_eoi_reg)
		else $error("CR not followed by LF with EOI");
	switch_order_a: assert property (@(posedge clk) disable iff (!nrst)
		!captured |=> stored[`IBA_ADDR_TOP] == $past(addr_switch_msb)
			&& stored[`IBA_ADDR_BOTTOM] == $past(addr_switch_lsb))
		else $error("switch bit order wrong");
endmodule

/* File: hdl/iba_pkg.sv */
package iba_pkg;
	typedef logic [4:0] iba_addr_t;
	typedef logic [7:0] iba_byte_t;
	typedef enum logic [2:0] {
		IBA_TX_IDLE = 3'h1,
		IBA_TX_CR = 3'h2,
		IBA_TX_LF = 3'h4
	} iba_tx_state_t;
endpackage

/* File: testbench/iba_ctrl_model.sv */
`timescale 1ns/10ps
// Bus controller: sends bus bytes and accepts talker bytes
module iba_ctrl_model
	import iba_pkg::*;
(
	input wire logic clk,
	output logic rx_valid,
	output iba_pkg::iba_byte_t rx_data,
	output logic rx_atn,
	output logic rx_eoi,
	output logic tx_accept,
	input wire logic out_valid_q,
	input wire logic out_eoi_q,
	input iba_pkg::iba_byte_t out_data_q
);
	logic [8:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		rx_atn = 1'b0;
		rx_eoi = 1'b0;
		tx_accept = 1'b0;
	end
	// one byte per call, address bytes under atn
	task send(input logic atn, input logic eoi, input iba_byte_t d);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data = d;
		rx_atn = atn;
		rx_eoi = eoi;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~d; // Released lines show no stale byte
		rx_atn = 1'b0;
		rx_eoi = 1'b0;
	endtask
	// Slow acceptor, logs each byte it takes
	always @(negedge clk) begin
		tx_accept <= out_valid_q & !tx_accept;
		if (out_valid_q & !tx_accept) begin
			got.push_back({out_eoi_q, out_data_q});
		end
	end
endmodule

/* File: testbench/iba_match_tb.sv */
`timescale 1ns/10ps
module iba_match_tb;
	import iba_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] sw = 5'h00;
	logic nl_mode = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	iba_byte_t tx_data = 8'h00;
	logic rx_valid, rx_atn, rx_eoi, tx_accept, listen_q, talk_q, msg_valid_q, msg_end_q;
	logic tx_ready_q, out_valid_q, out_eoi_q;
	iba_byte_t rx_data, msg_data_q, out_data_q;
	iba_addr_t primary_addr_q;
	logic [8:0] mq[$];
	int bad_count = 0;
	int checks_done = 0;
	initial begin
		forever #20 clk = ~clk;
	end
	iba_match u_iba_match(.clk(clk), .nrst(nrst), .addr_switch_msb(sw[4]), .addr_switch_bit3(sw[3]),
		.addr_switch_bit2(sw[2]), .addr_switch_bit1(sw[1]), .addr_switch_lsb(sw[0]),
		.newline_or_end_termination(nl_mode), .rx_valid(rx_valid), .rx_data(rx_data), .rx_atn(rx_atn),
		.rx_eoi(rx_eoi), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_accept(tx_accept),
		.listen_q(listen_q), .talk_q(talk_q), .msg_valid_q(msg_valid_q), .msg_data_q(msg_data_q),
		.msg_end_q(msg_end_q), .tx_ready_q(tx_ready_q), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
		.out_eoi_q(out_eoi_q), .primary_addr_q(primary_addr_q));
	iba_ctrl_model u_iba_ctrl_model(.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_atn(rx_atn),
		.rx_eoi(rx_eoi), .tx_accept(tx_accept), .out_valid_q(out_valid_q), .out_eoi_q(out_eoi_q),
		.out_data_q(out_data_q));
	// Received message bytes, sampled mid-cycle
	always @(negedge clk) begin
		if (msg_valid_q === 1'b1) begin
			mq.push_back({msg_end_q, msg_data_q});
		end
	end
	task chk(input string n, input logic [8:0] e, input logic [8:0] s);
		checks_done++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Power-up with a switch setting, then move the switches
	task t_power(input logic [4:0] a);
		nrst = 1'b0;
		sw = a;
		repeat (12) @(negedge clk);
		chk("reset addr", 9'h01C, primary_addr_q);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		sw = ~a;
		repeat (3) @(negedge clk);
		chk("captured addr", {4'h0, a}, primary_addr_q);
	endtask
	task t_rx(input logic atn, input logic eoi, input logic [7:0] d);
		u_iba_ctrl_model.send(atn, eoi, d);
		repeat (2) @(negedge clk);
	endtask
	task t_tx(input logic [7:0] d, input logic l);
		@(negedge clk);
		tx_valid = 1'b1;
		tx_data = d;
		tx_last = l;
		#1;
		while (!(talk_q & tx_ready_q & (!out_valid_q | tx_accept))) begin
			@(negedge clk);
			#1;
		end
		@(negedge clk);
		tx_valid = 1'b0;
	endtask
	task t_out(input logic [8:0] e[$]);
		repeat (12) @(negedge clk);
		chk("out count", e.size(), u_iba_ctrl_model.got.size());
		foreach (e[i]) begin
			if (u_iba_ctrl_model.got.size() > 0) begin
				chk("out byte", e[i], u_iba_ctrl_model.got.pop_front());
			end
		end
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	// Address bytes: secondary, foreign address, stray data, then own listen
	task sc_address;
		t_power(5'h0B);
		t_rx(1'b1, 1'b0, {1'b0, 2'h3, 5'h0B});
		t_rx(1'b1, 1'b0, {1'b0, 2'h1, 5'h0A});
		t_rx(1'b0, 1'b0, 8'h33);
		chk("not addressed", 9'h000, {7'h00, talk_q, listen_q});
		chk("stray msg count", 9'h000, 9'(mq.size()));
		t_rx(1'b1, 1'b0, {1'b0, 2'h1, 5'h0B});
		t_rx(1'b1, 1'b0, {1'b0, 2'h3, 5'h00});
		chk("listen", 9'h001, {8'h00, listen_q});
	endtask
	// Message data in both termination modes
	task sc_message;
		t_rx(1'b0, 1'b0, 8'h0A);
		t_rx(1'b0, 1'b1, 8'h55);
		nl_mode = 1'b1;
		t_rx(1'b0, 1'b0, 8'h0A);
		chk("msg count", 9'h003, 9'(mq.size()));
		chk("msg lf plain", 9'h00A, mq.pop_front());
		chk("msg eoi", 9'h155, mq.pop_front());
		chk("msg lf end", 9'h10A, mq.pop_front());
	endtask
	// Talker output in both termination modes
	task sc_output;
		t_rx(1'b1, 1'b0, {1'b0, 2'h2, 5'h0B});
		chk("talk", 9'h001, {8'h00, talk_q});
		nl_mode = 1'b0;
		t_tx(8'h41, 1'b0);
		t_tx(8'h42, 1'b1);
		t_out('{9'h041, 9'h142});
		nl_mode = 1'b1;
		t_tx(8'h43, 1'b1);
		chk("ready in tail", 9'h000, {8'h00, tx_ready_q});
		t_out('{9'h043, 9'h00D, 9'h10A});
		chk("ready after tail", 9'h001, {8'h00, tx_ready_q});
	endtask
	// Address 31 after a second power-up
	task sc_offbus;
		t_power(5'h1F);
		t_rx(1'b1, 1'b0, {1'b0, 2'h1, 5'h1F});
		t_rx(1'b1, 1'b0, {1'b0, 2'h2, 5'h1F});
		chk("off bus", 9'h000, {7'h00, talk_q, listen_q});
	endtask
	initial begin
		sc_address();
		sc_message();
		sc_output();
		sc_offbus();
		stop_test();
	end
endmodule
